//--- verilog/fhc_consts.svh
// Constants for the flash host sequencer: opcodes, status bits, pin timing
`ifndef FHC_CONSTS_SVH
`define FHC_CONSTS_SVH
`define FHC_OP_PROG_SETUP    8'h40
`define FHC_OP_PROG_ALT      8'h10
`define FHC_OP_READ_STATUS   8'h70
`define FHC_OP_CLEAR_STATUS  8'h50
`define FHC_OP_READ_ARRAY    8'hFF
`define FHC_OP_ERS_SUSPEND   8'hB0
`define FHC_OP_ERS_RESUME    8'hD0
`define FHC_OP_PRG_SUSPEND   8'hB0
`define FHC_OP_PRG_RESUME    8'hD0
`define FHC_OP_LOCK_SETUP    8'h60
`define FHC_OP_BLK_LOCK_CONF 8'h01
`define FHC_OP_PERM_LOCK_CNF 8'hF1
`define FHC_SR_READY         7
`define FHC_SR_ERS_SUSP      6
`define FHC_SR_ERS_ERR       5
`define FHC_SR_PRG_ERR       4
`define FHC_SR_SUPPLY_LOW    3
`define FHC_SR_PRG_SUSP      2
`define FHC_SR_LOCK_VIOL     1
`define FHC_STROBE_NS        75
`define FHC_STROBE_CYC       ((`FHC_STROBE_NS + 24) / 25)
`define FHC_ACCESS_NS        100
`define FHC_ACCESS_CYC       ((`FHC_ACCESS_NS + 24) / 25)
`endif

//--- verilog/fhc_pkg.sv
// Types shared by the flash host sequencer files
package fhc_pkg;
  // User-side command codes
  typedef enum logic [3:0] {
    FHC_CMD_PROGRAM    = 4'h0,
    FHC_CMD_READ_STAT  = 4'h1,
    FHC_CMD_CLEAR_STAT = 4'h2,
    FHC_CMD_READ_ARRAY = 4'h3,
    FHC_CMD_ERS_SUSP   = 4'h4,
    FHC_CMD_ERS_RESUME = 4'h5,
    FHC_CMD_PRG_SUSP   = 4'h6,
    FHC_CMD_PRG_RESUME = 4'h7,
    FHC_CMD_BLK_LOCK   = 4'h8,
    FHC_CMD_PERM_LOCK  = 4'h9
  } fhc_cmd_e;
  // A user request
  typedef struct packed {
    fhc_cmd_e    cmd;
    logic [19:0] addr;
    logic [15:0] data;
  } fhc_req_s;
  // Decoded status flags
  typedef struct packed {
    logic ready;
    logic ers_susp;
    logic ers_err;
    logic prg_err;
    logic supply_low;
    logic prg_susp;
    logic lock_viol;
  } fhc_stat_s;
  // Parallel bus pins toward the flash
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [19:0] addr;
  } fhc_pins_s;
endpackage : fhc_pkg

//--- verilog/fhc_bus_cycle.sv
// One asynchronous bus cycle (write or read) on the flash pins
`timescale 1ns/100ps
`include "fhc_consts.svh"
module fhc_bus_cycle
  import fhc_pkg::*;
#(
  parameter int STROBE_CYC = `FHC_STROBE_CYC,
  parameter int ACCESS_CYC = `FHC_ACCESS_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic        write_in,
  input  wire logic [19:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [15:0] dq_sync_in,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  output fhc_pins_s        pins_out,
  output logic [15:0]      dq_out,
  output logic             dq_oe_out
);
  localparam int CW = 8;
  // Phase: 0 idle, 1 strobe low, 2 recovery high
  logic [1:0]    ph_q, ph_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          wr_q, wr_d;
  logic [19:0]   addr_q, addr_d;
  logic [15:0]   wd_q, wd_d;
  logic [15:0]   rd_q, rd_d;
  logic          done_q, done_d;

  // Next-state for the cycle timer
  always_comb begin
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    done_d = 1'b0;
    case (ph_q)
      2'd0: if (start_in) begin
        ph_d   = 2'd1;
        wr_d   = write_in;
        addr_d = addr_in;
        wd_d   = wdata_in;
        // Read needs the extra two sync stages before data is valid
        cnt_d  = write_in ? CW'(STROBE_CYC) : CW'(ACCESS_CYC + 2);
      end
      2'd1: if (cnt_q == '0) begin
        // Data captured by flash on the rising write strobe
        if (!wr_q) rd_d = dq_sync_in;
        ph_d  = 2'd2;
        cnt_d = CW'(STROBE_CYC);
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
      // Strobe high again so the next status read relatches
      2'd2: if (cnt_q == '0) begin
        ph_d   = 2'd0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
      default: ph_d = 2'd0;
    endcase
  end

  // Register the timer state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_q   <= 2'd0;
      cnt_q  <= '0;
      wr_q   <= 1'b0;
      addr_q <= 20'h00000;
      wd_q   <= 16'h0000;
      rd_q   <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  // Pin drive follows the phase
  always_comb begin
    pins_out.addr = addr_q;
    pins_out.ce_n = (ph_q != 2'd1);
    pins_out.we_n = !(ph_q == 2'd1 && wr_q);
    pins_out.oe_n = !(ph_q == 2'd1 && !wr_q);
  end
  assign dq_out    = wd_q;
  assign dq_oe_out = (ph_q != 2'd0) && wr_q;
  assign done_out  = done_q;
  assign rdata_out = rd_q;
endmodule : fhc_bus_cycle

//--- verilog/fhc_host.sv
// Host sequencer that drives a parallel NOR flash through its pins
// Notes on behaviour
// - Program is setup opcode then address/data write
// - After erase suspend, read status and check
// - Erase-suspended allows read, program, status, resume
// - Hold reset high, protect steady while suspended
// - After program suspend, read status and check
// - Program-suspended allows read, status, resume only
// - Lock set is setup then confirm write
// - Check program-error after lock, clear on error (the host only raises rsp_fail_out; the user issues the clear)
// - Clear status ignored while suspended
`timescale 1ns/100ps
`include "fhc_consts.svh"
module fhc_host
  import fhc_pkg::*;
#(
  // Opcodes not fixed by the device text are left configurable
  parameter logic [7:0] OP_READ_ARRAY    = `FHC_OP_READ_ARRAY,
  parameter logic [7:0] OP_ERS_SUSPEND   = `FHC_OP_ERS_SUSPEND,
  parameter logic [7:0] OP_ERS_RESUME    = `FHC_OP_ERS_RESUME,
  parameter logic [7:0] OP_PRG_SUSPEND   = `FHC_OP_PRG_SUSPEND,
  parameter logic [7:0] OP_PRG_RESUME    = `FHC_OP_PRG_RESUME,
  parameter logic [7:0] OP_LOCK_SETUP    = `FHC_OP_LOCK_SETUP,
  parameter logic [7:0] OP_BLK_LOCK_CONF = `FHC_OP_BLK_LOCK_CONF,
  parameter logic [7:0] OP_PERM_LOCK_CNF = `FHC_OP_PERM_LOCK_CNF,
  parameter logic       USE_ALT_PROGRAM  = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // User side
  input  wire logic        req_valid_in,
  input  fhc_req_s         req_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  output fhc_stat_s        rsp_stat_out,
  output logic             rsp_fail_out,
  output logic             busy_out,
  // Flash pins
  output fhc_pins_s        flash_pins_out,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_out,
  input  wire logic        ready_busy_in,
  output logic             reset_powerdown_n_out,
  output logic             boot_protect_n_out,
  input  wire logic        boot_protect_req_in
);
  // States in Gray order along the main path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD1  = 3'b001,
    ST_CMD2  = 3'b011,
    ST_POLL  = 3'b010,
    ST_DONE  = 3'b110,
    ST_RDATA = 3'b111
  } fhc_state_e;

  fhc_state_e  st_q, st_d;
  fhc_req_s    req_q, req_d;
  logic        ers_susp_q, ers_susp_d;  // Host view: erase suspended
  logic        prg_susp_q, prg_susp_d;  // Host view: program suspended
  logic        prot_q, prot_d;          // Boot-protect level held out
  logic [15:0] rsp_q, rsp_d;
  logic        rv_q, rv_d;
  logic        fail_q, fail_d;
  logic        go;
  logic        bc_start, bc_write, bc_done, bc_busy;
  logic [19:0] bc_addr;
  logic [15:0] bc_wdata, bc_rdata;
  logic [15:0] dq_s1_q, dq_s2_q;        // Data pin synchroniser
  logic        rb_s1_q, rb_s2_q;        // Ready pin synchroniser
  logic        legal, rd_pending_q, rd_pending; // Legal command; status read in flight

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_in;
      rb_s2_q <= rb_s1_q;
    end
  end

  // Command legality against the suspend state
  always_comb begin
    legal = 1'b1;
    if (prg_susp_q) begin
      legal = req_in.cmd inside {FHC_CMD_READ_ARRAY, FHC_CMD_READ_STAT,
                                 FHC_CMD_PRG_RESUME};
    end else if (ers_susp_q) begin
      legal = req_in.cmd inside {FHC_CMD_READ_ARRAY, FHC_CMD_READ_STAT,
                                 FHC_CMD_PROGRAM, FHC_CMD_ERS_RESUME,
                                 FHC_CMD_PRG_SUSP};
    end
    // Clearing flags is not functional while suspended
    if (req_in.cmd == FHC_CMD_CLEAR_STAT && (ers_susp_q || prg_susp_q)) legal = 1'b0;
  end

  assign req_ready_out = (st_q == ST_IDLE);
  assign go            = req_valid_in && req_ready_out;

  // First bus write opcode per command
  function automatic logic [15:0] first_op(input fhc_cmd_e c);
    logic [7:0] op;
    op = `FHC_OP_READ_STATUS;
    case (c)
      FHC_CMD_PROGRAM:    op = USE_ALT_PROGRAM ? `FHC_OP_PROG_ALT : `FHC_OP_PROG_SETUP;
      FHC_CMD_CLEAR_STAT: op = `FHC_OP_CLEAR_STATUS;
      FHC_CMD_READ_ARRAY: op = OP_READ_ARRAY;
      FHC_CMD_ERS_SUSP:   op = OP_ERS_SUSPEND;
      FHC_CMD_ERS_RESUME: op = OP_ERS_RESUME;
      FHC_CMD_PRG_SUSP:   op = OP_PRG_SUSPEND;
      FHC_CMD_PRG_RESUME: op = OP_PRG_RESUME;
      FHC_CMD_BLK_LOCK,
      FHC_CMD_PERM_LOCK:  op = OP_LOCK_SETUP;
      default:            op = `FHC_OP_READ_STATUS;
    endcase
    return {8'h00, op};
  endfunction

  // Main sequencer next-state
  always_comb begin
    st_d       = st_q;
    req_d      = req_q;
    ers_susp_d = ers_susp_q;
    prg_susp_d = prg_susp_q;
    prot_d     = prot_q;
    rsp_d      = rsp_q;
    rv_d       = 1'b0;
    fail_d     = fail_q;
    bc_start   = 1'b0;
    bc_write   = 1'b1;
    bc_addr    = req_q.addr;
    bc_wdata   = first_op(req_q.cmd);
    case (st_q)
      ST_IDLE: if (go) begin
        req_d = req_in;
        if (!legal) begin
          // Refused locally, nothing reaches the pins
          fail_d = 1'b1;
          rv_d   = 1'b1;
        end else begin
          fail_d = 1'b0;
          // Protect level is frozen while any operation is suspended
          // A protect request drives the active-low pin low
          if (!ers_susp_q && !prg_susp_q) prot_d = !boot_protect_req_in;
          st_d = ST_CMD1;
        end
      end
      ST_CMD1: begin
        bc_start = 1'b1;
        st_d     = ST_CMD2;
      end
      ST_CMD2: if (bc_done) begin
        case (req_q.cmd)
          // Second write carries address and data
          FHC_CMD_PROGRAM: begin
            bc_start = 1'b1;
            bc_wdata = req_q.data;
            st_d     = ST_POLL;
          end
          // Confirm inside target block or anywhere
          FHC_CMD_BLK_LOCK, FHC_CMD_PERM_LOCK: begin
            bc_start = 1'b1;
            bc_wdata = {8'h00, (req_q.cmd == FHC_CMD_BLK_LOCK) ?
                               OP_BLK_LOCK_CONF : OP_PERM_LOCK_CNF};
            st_d     = ST_POLL;
          end
          FHC_CMD_READ_ARRAY: begin
            bc_start = 1'b1;
            bc_write = 1'b0;
            st_d     = ST_RDATA;
          end
          // Late suspend leaves read-array mode: write read status first
          default: begin
            bc_start = 1'b1;
            bc_write = req_q.cmd inside {FHC_CMD_ERS_SUSP, FHC_CMD_PRG_SUSP};
            bc_wdata = {8'h00, `FHC_OP_READ_STATUS};
            st_d     = bc_write ? ST_POLL : ST_DONE;
          end
        endcase
      end
      // Wait on the pin, then read status
      ST_POLL: if (bc_done) begin
        st_d = ST_DONE;
      end
      ST_DONE: if (!bc_busy && (rb_s2_q || req_q.cmd inside {FHC_CMD_ERS_SUSP,
               FHC_CMD_PRG_SUSP, FHC_CMD_READ_STAT, FHC_CMD_CLEAR_STAT})) begin
        if (rd_pending) begin
          // Status now valid: flags decide suspend tracking
          rsp_d      = bc_rdata;
          ers_susp_d = bc_rdata[`FHC_SR_ERS_SUSP];
          prg_susp_d = bc_rdata[`FHC_SR_PRG_SUSP];
          // Program-error or erase-error in the status read marks failure
          fail_d     = bc_rdata[`FHC_SR_PRG_ERR] || bc_rdata[`FHC_SR_ERS_ERR];
          rv_d       = 1'b1;
          st_d       = ST_IDLE;
        end else begin
          bc_start = 1'b1;
          bc_write = 1'b0;
        end
      end
      ST_RDATA: if (bc_done) begin
        rsp_d = bc_rdata;
        rv_d  = 1'b1;
        st_d  = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Tracks a status read in flight within the done state
  assign rd_pending = rd_pending_q && bc_done;
  assign bc_busy    = rd_pending_q && !bc_done;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pending_q <= 1'b0;
    end else if (st_q != ST_DONE) begin
      rd_pending_q <= (st_d == ST_DONE) && bc_start;
    end else if (bc_start) begin
      rd_pending_q <= 1'b1;
    end else if (bc_done) begin
      rd_pending_q <= 1'b0;
    end
  end

  // Register the sequencer state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q       <= ST_IDLE;
      req_q      <= '0;
      ers_susp_q <= 1'b0;
      prg_susp_q <= 1'b0;
      prot_q     <= 1'b1;
      rsp_q      <= 16'h0000;
      rv_q       <= 1'b0;
      fail_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      req_q      <= req_d;
      ers_susp_q <= ers_susp_d;
      prg_susp_q <= prg_susp_d;
      prot_q     <= prot_d;
      rsp_q      <= rsp_d;
      rv_q       <= rv_d;
      fail_q     <= fail_d;
    end
  end

  // One bus cycle engine for all writes and reads
  fhc_bus_cycle u_cycle (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (bc_start),
    .write_in   (bc_write),
    .addr_in    (bc_addr),
    .wdata_in   (bc_wdata),
    .dq_sync_in (dq_s2_q),
    .done_out   (bc_done),
    .rdata_out  (bc_rdata),
    .pins_out   (flash_pins_out),
    .dq_out     (dq_out),
    .dq_oe_out  (dq_oe_out)
  );

  // Reset pin follows the host reset, so stays high in operation, notably while suspended
  assign reset_powerdown_n_out = rst_n_in;
  assign boot_protect_n_out    = prot_q;
  assign rsp_valid_out         = rv_q;
  assign rsp_data_out          = rsp_q;
  assign rsp_fail_out          = fail_q;
  assign busy_out              = (st_q != ST_IDLE);
  // Status word decoded into named flags
  assign rsp_stat_out = fhc_stat_s'(rsp_q[`FHC_SR_READY:`FHC_SR_LOCK_VIOL]);
  // Erase resume is only issued by the user once programs finished
endmodule : fhc_host

//--- sim/fhc_host_sva.sv
// Port-level checks of the flash host sequencer, bound into the design
`timescale 1ns/100ps
module fhc_host_sva
  import fhc_pkg::*;
(
  input wire logic      clk_in,
  input wire logic      rst_n_in,
  input wire logic      req_valid_in,
  input wire logic      req_ready_out,
  input wire logic      rsp_valid_out,
  input wire fhc_stat_s rsp_stat_out,
  input wire logic      busy_out,
  input wire fhc_pins_s flash_pins_out,
  input wire logic      dq_oe_out,
  input wire logic      reset_powerdown_n_out,
  input wire logic      boot_protect_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // A write strobe always carries host-driven data
  a_write_drives_dq: assert property (!flash_pins_out.we_n && !flash_pins_out.ce_n |->
    dq_oe_out) else $error("write strobe without data drive");
  // Strobe of 75 ns is three cycles low
  a_strobe_width: assert property ($fell(flash_pins_out.we_n) |->
    !flash_pins_out.we_n [*3]) else $error("write strobe too short");
  // Reads never fight the flash on the data lines
  a_read_no_drive: assert property (!flash_pins_out.oe_n |->
    !dq_oe_out && flash_pins_out.we_n) else $error("drive during read");
  // Output enable returns high so the next status read relatches
  a_read_ends: assert property ($fell(flash_pins_out.oe_n) |->
    ##[1:60] flash_pins_out.oe_n) else $error("read strobe held");
  // Idle or refused work leaves the pins quiet
  a_idle_quiet: assert property (!busy_out |->
    flash_pins_out.ce_n && !dq_oe_out) else $error("pin activity while idle");
  a_take_busy: assert property (req_valid_in && req_ready_out |=> busy_out ^ rsp_valid_out)
    else $error("request taken without work or answer");
  a_rsp_pulse: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
  a_powerdown_high: assert property (reset_powerdown_n_out)
    else $error("reset pin dropped in operation");
  // Protect level frozen while a suspension is reported
  a_protect_hold: assert property ((rsp_stat_out.ers_susp || rsp_stat_out.prg_susp)
    && !busy_out |=> $stable(boot_protect_n_out)) else $error("protect moved in suspend");
endmodule : fhc_host_sva
bind fhc_host fhc_host_sva chk_u (.clk_in, .rst_n_in, .req_valid_in, .req_ready_out,
  .rsp_valid_out, .rsp_stat_out, .busy_out, .flash_pins_out, .dq_oe_out,
  .reset_powerdown_n_out, .boot_protect_n_out);

//--- sim/fhc_flash_model.sv
// Behavioural model of the parallel flash that the host sequencer drives
`timescale 1ns/100ps
`include "fhc_consts.svh"
module fhc_flash_model
  import fhc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire fhc_pins_s   pins_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        boot_protect_n_in,
  input  wire logic        supply_low_in,
  input  wire logic        kick_in,
  output logic [15:0]      dq_out,
  output logic             rb_low_out
);
  logic [15:0] mem [16];   // Array words by addr[3:0]
  logic [15:0] blk_lock;   // Lock-bit per block addr[19:16]; block F is boot
  logic [6:1]  sr;         // Stored status flags
  logic [7:0]  setup;      // First opcode of a two-write sequence
  logic [15:0] lat, wd;    // Read latch, last write data
  logic [19:0] wa;         // Last write address
  logic        perm, rd_stat, rdy, wr;
  int          busy, ers_left; // Work left on program/lock and on erase
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {blk_lock, sr, setup, lat, perm, rd_stat, busy, ers_left} = '0;
  end
  // Suspend freezes work; erase waits for pending programs
  always @(posedge clk_in) begin
    if (wr) begin
      wd = dq_in;
      wa = pins_in.addr;
    end
    if (kick_in) ers_left = 200;
    else if (busy > 0) busy = sr[2] ? busy : busy - 1;
    else if (ers_left > 0 && !sr[6]) ers_left--;
  end
  // Suspended device floats the pin (pulled high)
  assign rdy = (busy == 0 || sr[2]) && (ers_left == 0 || sr[6]);
  assign rb_low_out = !rdy;
  assign wr = !pins_in.we_n && !pins_in.ce_n;
  // Command decoder acts as the write strobe ends
  always @(negedge wr) begin
    if (setup == `FHC_OP_PROG_SETUP || setup == `FHC_OP_PROG_ALT) begin
      if (supply_low_in) {sr[4], sr[3]} = 2'b11;
      else if (blk_lock[wa[19:16]] || (wa[19:16] == 4'hF && !boot_protect_n_in))
        {sr[4], sr[1]} = 2'b11;
      else begin
        mem[wa[3:0]] = mem[wa[3:0]] & wd;
        busy = 20;
      end
      setup = '0;
    end else if (setup == `FHC_OP_LOCK_SETUP) begin
      if (wd[7:0] == `FHC_OP_BLK_LOCK_CONF && perm) {sr[4], sr[1]} = 2'b11;
      else if (wd[7:0] == `FHC_OP_BLK_LOCK_CONF) blk_lock[wa[19:16]] = 1'b1;
      else if (wd[7:0] == `FHC_OP_PERM_LOCK_CNF) perm = 1'b1;
      else {sr[5], sr[4]} = 2'b11;
      busy = 10;
      setup = '0;
    end else begin
      rd_stat = 1'b1;
      case (wd[7:0])
        `FHC_OP_PROG_SETUP, `FHC_OP_PROG_ALT: if (!sr[2]) setup = wd[7:0];
        `FHC_OP_LOCK_SETUP: if (!sr[2] && !sr[6]) setup = wd[7:0];
        `FHC_OP_CLEAR_STATUS: if (!sr[2] && !sr[6]) {sr[5:3], sr[1]} = '0;
        // Both suspends share one opcode; the running work decides
        `FHC_OP_PRG_SUSPEND:
          if (busy > 0 && !sr[2]) sr[2] = 1'b1;
          else if (ers_left > 0 && !sr[6]) sr[6] = 1'b1;
          else rd_stat = 1'b0;
        `FHC_OP_PRG_RESUME:
          if (sr[2]) sr[2] = 1'b0;
          else if (busy == 0) sr[6] = 1'b0;
        `FHC_OP_READ_ARRAY: rd_stat = 1'b0;
        default: ;
      endcase
    end
  end
  // Status captured as the read strobe falls
  always @(negedge pins_in.oe_n or negedge pins_in.ce_n)
    if (!pins_in.oe_n && !pins_in.ce_n)
      lat = rd_stat ? {8'h00, rdy, sr, 1'b0} : mem[pins_in.addr[3:0]];
  // A released bus shows the inverse of the last word, never a stale copy
  assign dq_out = (!pins_in.oe_n && !pins_in.ce_n) ? lat : ~lat;
endmodule : fhc_flash_model

//--- sim/test_fhc_host.sv
// Self-checking bench: host sequencer driving the behavioural flash
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module test_fhc_host
  import fhc_pkg::*;
;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
  logic        boot_protect_req_in = 1'b0, sup_low = 1'b0, kick = 1'b0;
  fhc_req_s    req_in = '0;
  logic        req_ready_out, rsp_valid_out, rsp_fail_out, busy_out, dq_oe_out;
  logic        reset_powerdown_n_out, boot_protect_n_out, rb_low, rb_n;
  logic [15:0] rsp_data_out, h_dq, f_dq, dq_bus;
  fhc_stat_s   rsp_stat_out;
  fhc_pins_s   flash_pins_out;
  int          failures = 0, samples_checked = 0;
  // Whoever enables drives the data lines; the ready pin has a pull-up
  assign dq_bus = dq_oe_out ? h_dq : f_dq;
  assign rb_n   = !rb_low;
  initial forever #12.5 clk_in = ~clk_in;
  fhc_host dut_u (.clk_in, .rst_n_in, .req_valid_in, .req_in, .req_ready_out, .rsp_valid_out,
    .rsp_data_out, .rsp_stat_out, .rsp_fail_out, .busy_out, .flash_pins_out, .dq_in(dq_bus),
    .dq_out(h_dq), .dq_oe_out, .ready_busy_in(rb_n), .reset_powerdown_n_out,
    .boot_protect_n_out, .boot_protect_req_in);
  fhc_flash_model fm_u (.clk_in, .pins_in(flash_pins_out), .dq_in(dq_bus),
    .boot_protect_n_in(boot_protect_n_out), .supply_low_in(sup_low), .kick_in(kick),
    .dq_out(f_dq), .rb_low_out(rb_low));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // One request, held until taken, then a bounded wait for its answer
  task automatic send(input fhc_cmd_e c, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    // One edge between requests, so a refused answer is never met by a new request
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    req_in = '{cmd: c, addr: a, data: d};
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 5000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 100 && rsp_valid_out !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : send
  task automatic t_program();
    send(FHC_CMD_PROGRAM, 20'h00003, 16'h5A3C);
    `CHK("prog fail", 1'b0, rsp_fail_out)
    `CHK("prog ready", 1'b1, rsp_stat_out.ready)
    `CHK("prog word", 16'h5A3C, fm_u.mem[3])
    send(FHC_CMD_PROGRAM, 20'h00003, 16'hFFFF);
    `CHK("reprog status", 8'h80, rsp_data_out[7:0])
    send(FHC_CMD_READ_ARRAY, 20'h00003, 16'h0000);
    `CHK("array word", 16'h5A3C, rsp_data_out)
    send(FHC_CMD_READ_STAT, 20'h00000, 16'h0000);
    `CHK("read status", 8'h80, rsp_data_out[7:0])
    $display("test program done");
  endtask : t_program
  task automatic t_supply();
    sup_low = 1'b1;
    send(FHC_CMD_PROGRAM, 20'h00005, 16'h0000);
    `CHK("low status", 8'h98, rsp_data_out[7:0])
    `CHK("low fail", 1'b1, rsp_fail_out)
    `CHK("low word", 16'hFFFF, fm_u.mem[5])
    sup_low = 1'b0;
    send(FHC_CMD_CLEAR_STAT, 20'h00000, 16'h0000);
    `CHK("cleared", 8'h80, rsp_data_out[7:0])
    $display("test supply done");
  endtask : t_supply
  task automatic t_lock();
    send(FHC_CMD_BLK_LOCK, 20'h20000, 16'h0000);
    `CHK("lock fail", 1'b0, rsp_fail_out)
    `CHK("lock bit", 1'b1, fm_u.blk_lock[2])
    send(FHC_CMD_PROGRAM, 20'h20001, 16'h0000);
    `CHK("locked status", 8'h92, rsp_data_out[7:0])
    `CHK("locked fail", 1'b1, rsp_fail_out)
    send(FHC_CMD_CLEAR_STAT, 20'h00000, 16'h0000);
    boot_protect_req_in = 1'b1;
    send(FHC_CMD_PROGRAM, 20'hF0004, 16'h0000);
    `CHK("boot status", 8'h92, rsp_data_out[7:0])
    boot_protect_req_in = 1'b0;
    send(FHC_CMD_CLEAR_STAT, 20'h00000, 16'h0000);
    $display("test lock done");
  endtask : t_lock
  task automatic t_erase();
    kick = 1'b1;
    @(negedge clk_in);
    kick = 1'b0;
    send(FHC_CMD_ERS_SUSP, 20'h00000, 16'h0000);
    `CHK("suspend status", 8'hC0, rsp_data_out[7:0])
    send(FHC_CMD_CLEAR_STAT, 20'h00000, 16'h0000);
    `CHK("clear refused", 1'b1, rsp_fail_out)
    send(FHC_CMD_BLK_LOCK, 20'h40000, 16'h0000);
    `CHK("lock refused", 1'b1, rsp_fail_out)
    send(FHC_CMD_PROGRAM, 20'h10002, 16'h1234);
    `CHK("susp prog bit", 1'b1, rsp_stat_out.ers_susp)
    `CHK("susp prog word", 16'h1234, fm_u.mem[2])
    send(FHC_CMD_ERS_RESUME, 20'h00000, 16'h0000);
    `CHK("resume bit", 1'b0, rsp_stat_out.ers_susp)
    send(FHC_CMD_ERS_SUSP, 20'h00000, 16'h0000);
    `CHK("late suspend", 8'h80, rsp_data_out[7:0])
    send(FHC_CMD_PRG_SUSP, 20'h00000, 16'h0000);
    `CHK("late prog suspend", 8'h80, rsp_data_out[7:0])
    $display("test erase suspend done");
  endtask : t_erase
  task automatic t_perm();
    send(FHC_CMD_PERM_LOCK, 20'h00000, 16'h0000);
    `CHK("perm fail", 1'b0, rsp_fail_out)
    send(FHC_CMD_BLK_LOCK, 20'h30000, 16'h0000);
    `CHK("perm status", 8'h92, rsp_data_out[7:0])
    `CHK("perm block", 1'b0, fm_u.blk_lock[3])
    $display("test permanent lock done");
  endtask : t_perm
  initial begin
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    t_program();
    t_supply();
    t_lock();
    t_erase();
    t_perm();
    conclude();
  end
endmodule : test_fhc_host
